/* shared/dbsac_map.vh */
// register map and field layout of the dual bus slot access control block
// assumes a 12-bit byte address from a plain strobe port with 32-bit data
`ifndef DBSAC_MAP_VH
`define DBSAC_MAP_VH

`define DBSAC_ADDR_W 12
`define DBSAC_OFF_CTRL 12'h000
`define DBSAC_OFF_STATUS 12'h004
`define DBSAC_CHAN_BASE_HI 4'h1
`define DBSAC_CH_VCI 3'h0
`define DBSAC_CH_RD_LO 3'h1
`define DBSAC_CH_RD_HI 3'h2
`define DBSAC_CH_WR_LO 3'h3
`define DBSAC_CH_WR_HI 3'h4

`define DBSAC_MOD_W 8
`define DBSAC_MOD_RESET 8'h00
`define DBSAC_VCI_W 20
`define DBSAC_CH_EN_BIT 31
`define DBSAC_NOCT 48
`define DBSAC_OFF_W 6
`define DBSAC_NPRI 3

`endif

/* sim/dbsac_checker.sv */
// port-level assertions for dbsac_top
// assumes one mclk domain and a synchronous active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module dbsac_checker #(
  parameter NCH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] qa_empty,
  input wire logic [5:0] qa_req_free,
  input wire logic [5:0] qa_seg_sent,
  input wire logic [5:0] qa_req_write,
  input wire logic [1:0] hdr_valid,
  input wire logic [1:0] oct_valid,
  input wire logic [1:0] oct_out_valid,
  input wire logic [15:0] oct_out,
  input wire logic [15:0] iso_wr_data,
  input wire logic [1:0] iso_wr_take,
  input wire logic [1:0] iso_rd_valid,
  input wire logic [1:0] conv_valid,
  input wire logic [2*NCH-1:0] conv_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_grant_a_empty: assert property (qa_seg_sent[2:0] != 3'h0 |-> qa_empty[0])
    else $error("bus A grant without empty slot");
  a_grant_b_empty: assert property (qa_seg_sent[5:3] != 3'h0 |-> qa_empty[1])
    else $error("bus B grant without empty slot");
  a_grant_one_level: assert property ($onehot0(qa_seg_sent[2:0]) && $onehot0(qa_seg_sent[5:3]))
    else $error("two priorities granted one slot");
  a_req_bit_free: assert property ((qa_req_write & ~qa_req_free) == 6'h00)
    else $error("request bit written while not free");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_octet_follow: assert property (oct_out_valid == $past(oct_valid))
    else $error("octet not forwarded one cycle later");
  a_take_octet: assert property ((iso_wr_take & ~oct_valid) == 2'h0)
    else $error("write take without octet");
  a_write_lands: assert property (iso_wr_take[0] |=> oct_out[7:0] == $past(iso_wr_data[7:0]))
    else $error("written octet not placed in slot");
  a_read_follow: assert property ((iso_rd_valid & ~$past(oct_valid)) == 2'h0)
    else $error("read octet without source octet");
  a_conv_header: assert property (conv_valid[0] |-> $past(hdr_valid[0]) && $onehot(conv_sel[1:0]))
    else $error("steering not one-hot after header");
endmodule // dbsac_checker
`default_nettype wire

/* sim/dbsac_far.sv */
// head of bus model for one bus: a header, then a train of payload octets
// assumes start pulses are spaced beyond the octet train
`timescale 1ns/1ps
`default_nettype none
module dbsac_far #(
  parameter NOCT = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic pa,
  input wire logic [19:0] virtual_channel_id,
  output logic hdr_valid,
  output logic hdr_pa,
  output logic [19:0] hdr_vci,
  output logic oct_valid,
  output logic [7:0] oct_in
);
  logic [4:0] left;
  always @(posedge mclk) begin
    hdr_valid <= 1'b0;
    oct_valid <= 1'b0;
    // idle lines keep moving so a stale value never looks valid
    oct_in <= ~oct_in;
    hdr_vci <= ~hdr_vci;
    hdr_pa <= ~hdr_pa;
    if (!rst_n) begin
      left <= 5'h00;
      oct_in <= 8'h00;
      hdr_vci <= 20'h00000;
      hdr_pa <= 1'b0;
    end else if (start) begin
      // slot type and channel id marked per issued slot
      hdr_valid <= 1'b1;
      hdr_pa <= pa;
      hdr_vci <= virtual_channel_id;
      left <= 5'(NOCT);
    end else if (left != 5'h00) begin
      oct_valid <= 1'b1;
      oct_in <= oct_in + {left, 3'h3};
      left <= left - 5'h01;
    end
  end
endmodule // dbsac_far
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for dbsac_top with two head of bus models
// assumes 200 MHz mclk and default design parameters
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] qa_empty = 2'h0;
  logic [5:0] qa_req_seen = 6'h00, qa_req_free = 6'h00, qa_seg_avail = 6'h00, qa_seg_sent, qa_req_write;
  logic [1:0] hdr_valid, hdr_pa, oct_valid, oct_out_valid, iso_wr_take, iso_rd_valid, iso_chan, conv_valid;
  logic [39:0] hdr_vci;
  logic [39:0] vs = 40'h0;
  logic [15:0] oct_in, oct_out, iso_rd_data;
  logic [15:0] iso_wr_data = 16'h0000;
  logic [15:0] rnd = 16'hF50F;
  logic [3:0] conv_sel;
  logic [1:0] start = 2'h0, pa = 2'h0;
  logic [19:0] v0 = 20'h0, v1 = 20'h0;
  logic [31:0] wm [0:1], rm [0:1];
  logic phv [0:1], pov [0:1], pr [0:1];
  logic [7:0] px [0:1], pd [0:1];
  logic w;
  integer err_total = 0, checks_done = 0, b, pm [0:1], pc [0:1], off [0:1];
  dbsac_top dbsac_top_i (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .qa_empty,
    .qa_req_seen, .qa_req_free, .qa_seg_avail, .qa_seg_sent, .qa_req_write, .hdr_valid, .hdr_pa, .hdr_vci,
    .oct_valid, .oct_in, .oct_out_valid, .oct_out, .iso_wr_data, .iso_wr_take, .iso_rd_valid, .iso_rd_data,
    .iso_chan, .conv_valid, .conv_sel);
  dbsac_far dbsac_far_i (.mclk, .rst_n, .start(start[0]), .pa(pa[0]), .virtual_channel_id(vs[19:0]), .hdr_valid(hdr_valid[0]),
    .hdr_pa(hdr_pa[0]), .hdr_vci(hdr_vci[19:0]), .oct_valid(oct_valid[0]), .oct_in(oct_in[7:0]));
  dbsac_far dbsac_far_i_b (.mclk, .rst_n, .start(start[1]), .pa(pa[1]), .virtual_channel_id(vs[39:20]), .hdr_valid(hdr_valid[1]),
    .hdr_pa(hdr_pa[1]), .hdr_vci(hdr_vci[39:20]), .oct_valid(oct_valid[1]), .oct_in(oct_in[15:8]));
  always #2.5 mclk = ~mclk;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function integer chan_of(input [19:0] v);
    chan_of = (v == v0) ? 0 : (v == v1) ? 1 : -1;
  endfunction
  always @(posedge mclk) begin
    rnd <= lfsr(rnd);
    iso_wr_data <= {rnd[7:0], rnd[15:8]};
  end
  task chk(input [47:0] seen, input [47:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d compares", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one cycle of queue events; grant and request write are combinational
  task qa(input [1:0] e, input [5:0] s, input [5:0] f, input [5:0] a, input [5:0] xs, input [5:0] xw);
    @(posedge mclk);
    qa_empty <= e;
    qa_req_seen <= s;
    qa_req_free <= f;
    qa_seg_avail <= a;
    #1 chk(qa_seg_sent, xs);
    chk(qa_req_write, xw);
    @(posedge mclk);
    qa_empty <= 2'h0;
    qa_req_seen <= 6'h00;
    qa_req_free <= 6'h00;
    qa_seg_avail <= 6'h00;
  endtask
  task slot(input integer k, input p, input [19:0] v);
    @(posedge mclk);
    start[k] <= 1'b1;
    pa[k] <= p;
    vs[20*k+:20] <= v;
    @(posedge mclk);
    start[k] <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  // negedge sampling: outputs of the previous octet are settled by then
  always @(negedge mclk) if (rst_n) for (b = 0; b < 2; b = b + 1) begin
    chk(conv_valid[b], phv[b] && pc[b] >= 0);
    if (phv[b] && pc[b] >= 0) chk(conv_sel[2*b+:2], 2'h1 << pc[b]);
    chk(oct_out_valid[b], pov[b]);
    if (pov[b]) chk(oct_out[8*b+:8], px[b]);
    chk(iso_rd_valid[b], pov[b] && pr[b]);
    if (pov[b] && pr[b]) chk({iso_chan[b], iso_rd_data[8*b+:8]}, {pm[b][0], pd[b]});
    phv[b] = hdr_valid[b];
    if (hdr_valid[b]) begin
      pc[b] = chan_of(hdr_vci[20*b+:20]);
      pm[b] = hdr_pa[b] ? pc[b] : -1;
      off[b] = 0;
    end
    pov[b] = oct_valid[b];
    w = oct_valid[b] && pm[b] >= 0 && wm[pm[b]][off[b]];
    pr[b] = oct_valid[b] && pm[b] >= 0 && rm[pm[b]][off[b]];
    chk(iso_wr_take[b], w);
    px[b] = w ? iso_wr_data[8*b+:8] : oct_in[8*b+:8];
    pd[b] = oct_in[8*b+:8];
    if (oct_valid[b]) off[b] = off[b] + 1;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    for (b = 0; b < 2; b = b + 1) begin
      pm[b] = -1;
      pc[b] = -1;
      off[b] = 0;
      phv[b] = 1'b0;
      pov[b] = 1'b0;
      pr[b] = 1'b0;
    end
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    qa(2'h0, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    rd(12'h004, 32'h0);
    qa(2'h0, 6'h00, 6'h01, 6'h00, 6'h00, 6'h01);
    wr(12'h000, 32'h2);
    rd(12'h000, 32'h2);
    qa(2'h0, 6'h00, 6'h00, 6'h09, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    rd(12'h004, 32'h00080001);
    qa(2'h0, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    qa(2'h0, 6'h00, 6'h08, 6'h00, 6'h00, 6'h08);
    rd(12'h004, 32'h00080000);
    qa(2'h0, 6'h04, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h0, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    qa(2'h2, 6'h00, 6'h00, 6'h00, 6'h08, 6'h00);
    rd(12'h004, 32'h00000101);
    qa(2'h0, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    qa(2'h0, 6'h04, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    rd(12'h004, 32'h00000100);
    qa(2'h0, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    qa(2'h1, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00);
    v0 = {rnd[3:0], rnd};
    v1 = v0 ^ 20'h00F0F;
    wm[1] = 32'h0;
    wr(12'h100, {12'h800, v0});
    wr(12'h120, {12'h800, v1});
    rm[0] = {rnd, rnd ^ 16'h3C3C} | 32'h00000001;
    wr(12'h104, rm[0]);
    wm[0] = {rnd, ~rnd} | 32'h00000001;
    wr(12'h10C, wm[0]);
    rm[1] = {rnd, rnd} | 32'h00000080;
    wr(12'h124, rm[1]);
    rd(12'h100, {12'h800, v0});
    rd(12'h10C, wm[0]);
    rd(12'h140, 32'h0);
    slot(0, 1'b1, v0);
    slot(0, 1'b0, v0);
    slot(1, 1'b1, v0 ^ 20'h12345);
    slot(1, 1'b1, v1);
    give_verdict;
  end
endmodule // tb
bind dbsac_top dbsac_checker #(.NCH(NCH)) dbsac_checker_i (.mclk, .rst_n, .reg_read, .reg_rdata, .qa_empty,
  .qa_req_free, .qa_seg_sent, .qa_req_write, .hdr_valid, .oct_valid, .oct_out_valid, .oct_out, .iso_wr_data,
  .iso_wr_take, .iso_rd_valid, .conv_valid, .conv_sel);
`default_nettype wire

/* verilog/dbsac_dq.v */
// distributed queue access for one bus: three priorities, request and
// countdown counters, bandwidth balancing counter and pending request count
// assumes slot and request events are one-cycle pulses on mclk
`timescale 1ns/1ps
`default_nettype none
`include "dbsac_map.vh"

module dbsac_dq #(
  parameter CW = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [`DBSAC_MOD_W-1:0] balance_modulus,
  input wire fwd_empty,
  input wire [2:0] rev_req,
  input wire [2:0] rev_free,
  input wire [2:0] seg_avail,
  output wire [2:0] seg_sent,
  output wire [2:0] req_write,
  output wire [2:0] queued,
  output wire [`DBSAC_MOD_W-1:0] bwb_count
);

  reg [`DBSAC_MOD_W-1:0] bwb;
  reg wrap;
  reg [2:0] q;
  reg [2:0] grant;
  wire [CW-1:0] cd_w [0:2];
  wire tx;

  // saturating counter step, never below zero nor above all ones
  function [CW-1:0] step;
    input [CW-1:0] v;
    input [2:0] inc;
    input dec;
    reg [CW+1:0] s;
    begin
      s = {2'b00, v} + {{(CW-1){1'b0}}, inc};
      if (dec && s != {(CW+2){1'b0}})
        s = s - {{(CW+1){1'b0}}, 1'b1};
      if (s[CW+1:CW] != 2'b00)
        step = {CW{1'b1}};
      else
        step = s[CW-1:0];
    end
  endfunction

  always @* begin
    grant = 3'b000;
    if (fwd_empty) begin
      if (q[2] && cd_w[2] == {CW{1'b0}})
        grant = 3'b100;
      else if (q[1] && cd_w[1] == {CW{1'b0}})
        grant = 3'b010;
      else if (q[0] && cd_w[0] == {CW{1'b0}})
        grant = 3'b001;
    end
  end

  assign tx = |grant;
  assign seg_sent = grant;
  assign queued = q;
  assign bwb_count = bwb;

  // one counter per bus; cleared on reset
  always @(posedge mclk) begin
    if (!rst_n) begin
      bwb <= `DBSAC_MOD_RESET;
      wrap <= 1'b0;
    end else begin
      wrap <= 1'b0;
      if (tx && balance_modulus != {`DBSAC_MOD_W{1'b0}}) begin
        if (bwb == balance_modulus - 1'b1) begin
          bwb <= {`DBSAC_MOD_W{1'b0}};
          wrap <= 1'b1;
        end else begin
          bwb <= bwb + 1'b1;
        end
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < `DBSAC_NPRI; p = p + 1) begin : g_pri
      reg [CW-1:0] rq;
      reg [CW-1:0] cd;
      reg [CW-1:0] pend;
      wire [2:0] ge_m = rev_req & (3'b111 << p);
      wire [2:0] gt_m = rev_req & (3'b110 << p);
      wire [1:0] ge_n = {1'b0, ge_m[0]} + {1'b0, ge_m[1]} + {1'b0, ge_m[2]};
      wire [1:0] gt_n = {1'b0, gt_m[0]} + {1'b0, gt_m[1]} + {1'b0, gt_m[2]};
      // wrap adds one to request or countdown, skipping one slot
      wire [2:0] inc_u = {1'b0, ge_n} + {2'b00, wrap};
      wire [2:0] inc_q = {1'b0, gt_n} + {2'b00, wrap};
      wire [CW-1:0] rq_u = step(rq, inc_u, fwd_empty);
      wire enq = !q[p] && seg_avail[p];
      assign cd_w[p] = cd;
      assign req_write[p] = (pend != {CW{1'b0}}) && rev_free[p];

      always @(posedge mclk) begin
        if (!rst_n) begin
          rq <= {CW{1'b0}};
          cd <= {CW{1'b0}};
          pend <= {CW{1'b0}};
          q[p] <= 1'b0;
        end else begin
          if (!q[p]) begin
            if (enq) begin
              cd <= rq_u;
              rq <= {CW{1'b0}};
              q[p] <= 1'b1;
            end else begin
              // count equal and higher requests, cancel on empty
              rq <= rq_u;
            end
          end else begin
            rq <= step(rq, {2'b00, rev_req[p]}, 1'b0);
            if (grant[p]) begin
              q[p] <= 1'b0;
              cd <= {CW{1'b0}};
            end else begin
              cd <= step(cd, inc_q, fwd_empty);
            end
          end
          // pending requests untouched by the wrap
          if (enq && !req_write[p])
            pend <= step(pend, 3'b001, 1'b0);
          else if (!enq && req_write[p])
            pend <= pend - 1'b1;
        end
      end
    end
  endgenerate

endmodule // dbsac_dq

`default_nettype wire

/* verilog/dbsac_top.v */
// dual bus slot access control: queued access on both buses with bandwidth
// balancing, and pre-arbitrated octet access with per-channel octet tables
// assumes slot framing logic on mclk delivers headers and octets as pulses
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dbsac_map.vh"

module dbsac_top #(
  parameter NCH = 2,
  parameter CIW = 1,
  parameter CW = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [`DBSAC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire [1:0] qa_empty,
  input wire [5:0] qa_req_seen,
  input wire [5:0] qa_req_free,
  input wire [5:0] qa_seg_avail,
  output wire [5:0] qa_seg_sent,
  output wire [5:0] qa_req_write,
  input wire [1:0] hdr_valid,
  input wire [1:0] hdr_pa,
  input wire [2*`DBSAC_VCI_W-1:0] hdr_vci,
  input wire [1:0] oct_valid,
  input wire [15:0] oct_in,
  output reg [1:0] oct_out_valid,
  output reg [15:0] oct_out,
  input wire [15:0] iso_wr_data,
  output wire [1:0] iso_wr_take,
  output reg [1:0] iso_rd_valid,
  output reg [15:0] iso_rd_data,
  output reg [2*CIW-1:0] iso_chan,
  output reg [1:0] conv_valid,
  output reg [2*NCH-1:0] conv_sel
);

  reg [`DBSAC_MOD_W-1:0] balance_modulus;
  reg [`DBSAC_VCI_W-1:0] ch_vci [0:NCH-1];
  reg [NCH-1:0] ch_en;
  reg [`DBSAC_NOCT-1:0] ch_rd [0:NCH-1];
  reg [`DBSAC_NOCT-1:0] ch_wr [0:NCH-1];
  wire [5:0] queued;
  wire [2*`DBSAC_MOD_W-1:0] bwb_count;

  wire chan_sel = reg_addr[11:8] == `DBSAC_CHAN_BASE_HI;
  wire [2:0] ch_idx = reg_addr[7:5];
  wire [2:0] ch_word = reg_addr[4:2];
  integer c;

  // register writes; channel blocks sit 32 bytes apart
  always @(posedge mclk) begin
    if (!rst_n) begin
      balance_modulus <= `DBSAC_MOD_RESET;
      ch_en <= {NCH{1'b0}};
      for (c = 0; c < NCH; c = c + 1) begin
        ch_vci[c] <= {`DBSAC_VCI_W{1'b0}};
        ch_rd[c] <= {`DBSAC_NOCT{1'b0}};
        ch_wr[c] <= {`DBSAC_NOCT{1'b0}};
      end
    end else if (reg_write) begin
      if (reg_addr == `DBSAC_OFF_CTRL)
        balance_modulus <= reg_wdata[`DBSAC_MOD_W-1:0];
      for (c = 0; c < NCH; c = c + 1) begin
        if (chan_sel && ch_idx == c[2:0]) begin
          case (ch_word)
            `DBSAC_CH_VCI: begin
              ch_vci[c] <= reg_wdata[`DBSAC_VCI_W-1:0];
              ch_en[c] <= reg_wdata[`DBSAC_CH_EN_BIT];
            end
            `DBSAC_CH_RD_LO: ch_rd[c][31:0] <= reg_wdata;
            `DBSAC_CH_RD_HI: ch_rd[c][`DBSAC_NOCT-1:32] <= reg_wdata[`DBSAC_NOCT-33:0];
            `DBSAC_CH_WR_LO: ch_wr[c][31:0] <= reg_wdata;
            `DBSAC_CH_WR_HI: ch_wr[c][`DBSAC_NOCT-1:32] <= reg_wdata[`DBSAC_NOCT-33:0];
            default: ;
          endcase
        end
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_read) begin
        if (reg_addr == `DBSAC_OFF_CTRL)
          reg_rdata <= {{(32-`DBSAC_MOD_W){1'b0}}, balance_modulus};
        else if (reg_addr == `DBSAC_OFF_STATUS)
          reg_rdata <= {10'h000, queued, bwb_count};
        for (c = 0; c < NCH; c = c + 1) begin
          if (chan_sel && ch_idx == c[2:0]) begin
            case (ch_word)
              `DBSAC_CH_VCI: reg_rdata <= {ch_en[c], {(31-`DBSAC_VCI_W){1'b0}}, ch_vci[c]};
              `DBSAC_CH_RD_LO: reg_rdata <= ch_rd[c][31:0];
              `DBSAC_CH_RD_HI: reg_rdata <= {{(64-`DBSAC_NOCT){1'b0}}, ch_rd[c][`DBSAC_NOCT-1:32]};
              `DBSAC_CH_WR_LO: reg_rdata <= ch_wr[c][31:0];
              `DBSAC_CH_WR_HI: reg_rdata <= {{(64-`DBSAC_NOCT){1'b0}}, ch_wr[c][`DBSAC_NOCT-1:32]};
              default: reg_rdata <= 32'h00000000;
            endcase
          end
        end
      end
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bus
      // one queue engine per bus, three priorities each
      dbsac_dq #(
        .CW(CW)
      ) u_dq (
        .mclk(mclk),
        .rst_n(rst_n),
        .balance_modulus(balance_modulus),
        .fwd_empty(qa_empty[b]),
        .rev_req(qa_req_seen[3*b+:3]),
        .rev_free(qa_req_free[3*b+:3]),
        .seg_avail(qa_seg_avail[3*b+:3]),
        .seg_sent(qa_seg_sent[3*b+:3]),
        .req_write(qa_req_write[3*b+:3]),
        .queued(queued[3*b+:3]),
        .bwb_count(bwb_count[`DBSAC_MOD_W*b+:`DBSAC_MOD_W])
      );

      reg hit;
      reg [CIW-1:0] idx;
      reg act;
      reg [CIW-1:0] ch;
      reg [`DBSAC_OFF_W-1:0] off;
      integer k;
      wire [`DBSAC_VCI_W-1:0] virtual_channel_id = hdr_vci[`DBSAC_VCI_W*b+:`DBSAC_VCI_W];
      wire in_range = off < `DBSAC_NOCT;
      wire wr_pos = act && in_range && ch_wr[ch][off];
      wire rd_pos = act && in_range && ch_rd[ch][off];

      // lowest matching channel wins, so one function per identifier
      always @* begin
        hit = 1'b0;
        idx = {CIW{1'b0}};
        for (k = NCH - 1; k >= 0; k = k - 1) begin
          if (ch_en[k] && ch_vci[k] == virtual_channel_id) begin
            hit = 1'b1;
            idx = k[CIW-1:0];
          end
        end
      end

      // take the user's octet at each write position
      assign iso_wr_take[b] = oct_valid[b] && wr_pos;

      always @(posedge mclk) begin
        if (!rst_n) begin
          act <= 1'b0;
          ch <= {CIW{1'b0}};
          off <= {`DBSAC_OFF_W{1'b0}};
          oct_out_valid[b] <= 1'b0;
          oct_out[8*b+:8] <= 8'h00;
          iso_rd_valid[b] <= 1'b0;
          iso_rd_data[8*b+:8] <= 8'h00;
          iso_chan[CIW*b+:CIW] <= {CIW{1'b0}};
          conv_valid[b] <= 1'b0;
          conv_sel[NCH*b+:NCH] <= {NCH{1'b0}};
        end else begin
          oct_out_valid[b] <= oct_valid[b];
          iso_rd_valid[b] <= 1'b0;
          conv_valid[b] <= 1'b0;
          if (hdr_valid[b]) begin
            off <= {`DBSAC_OFF_W{1'b0}};
            // unconfigured identifiers leave the slot alone
            act <= hdr_pa[b] && hit;
            ch <= idx;
            conv_valid[b] <= hit;
            conv_sel[NCH*b+:NCH] <= hit ? ({{(NCH-1){1'b0}}, 1'b1} << idx) : {NCH{1'b0}};
          end
          if (oct_valid[b]) begin
            if (in_range)
              off <= off + 1'b1;
            // write marked octets, pass the rest through
            oct_out[8*b+:8] <= wr_pos ? iso_wr_data[8*b+:8] : oct_in[8*b+:8];
            if (rd_pos) begin
              iso_rd_valid[b] <= 1'b1;
              iso_rd_data[8*b+:8] <= oct_in[8*b+:8];
              iso_chan[CIW*b+:CIW] <= ch;
            end
          end
        end
      end
    end
  endgenerate

endmodule // dbsac_top

`default_nettype wire
